// ==== shared/tmr_defines.vh ====
// Constants of the dual-slope PWM timer: APB offsets, fields, resets.
// Assumes a 100 MHz processor clock and a sampled oscillator input.
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TMR_OFF_CTLA   8'h00
`define TMR_OFF_CTLB   8'h04
`define TMR_OFF_COUNT  8'h08
`define TMR_OFF_CMPA   8'h0C
`define TMR_OFF_CMPB   8'h10
`define TMR_OFF_STAT   8'h14
`define TMR_OFF_FLAGS  8'h18
`define TMR_OFF_IEN    8'h1C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TMR_COMA_HI    7
`define TMR_COMA_LO    6
`define TMR_COMB_HI    5
`define TMR_COMB_LO    4
`define TMR_WGM2_BIT   3
`define TMR_CS_HI      2
`define TMR_AS_BIT     5
`define TMR_LOST_BIT   6
// Busy vector index
`define TMR_UB_CTLB    0
`define TMR_UB_CTLA    1
`define TMR_UB_CMPB    2
`define TMR_UB_CMPA    3
`define TMR_UB_COUNT   4
// Flag vector index
`define TMR_FL_OVF     0
`define TMR_FL_CMPA    1
`define TMR_FL_CMPB    2
// ----------------------------------------
// Values and timing
// ----------------------------------------
`define TMR_RST_BYTE   8'h00
`define TMR_MAX        8'hFF
`define TMR_WGM_PC_FF  3'h1
`define TMR_WGM_PC_A   3'h5
`define TMR_XFER_EDGES 2'h2
`define TMR_FLAG_SYNC  3
`define TMR_HALT_CYC   3'h4
`endif

// ==== rtl/tmr_pwm_timer.v ====
// 8-bit dual-slope PWM timer with optional oscillator clocking.
// Assumes APB master on MCLK; the oscillator input passes a two-stage
// synchroniser, and sleep strobes are sampled as ordinary synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.vh"

// Operation
// - Waveform select 1 or 5 counts dual-slope
// - Top is 0xFF, or compare A at 5
// - Up match clears, down match sets; inverting reverses
// - Select two non-inverted, three inverted PWM
// - Hold top one tick, then count down
// - Overflow flag set on reaching bottom
// - Period of 510 ticks with top 0xFF
// - Tick prescaled by 1,8,32,64,128,256,1024
// - Compare at bottom or max gives constant level
// - Unmatched transitions keep waveform symmetric around bottom
// - Async-mode writes to control, count and compare go through temporaries, latched after two edges
// - Pending count or compare write blocks matching
// - Wake logic needs one oscillator cycle rearm
// - Power-down wake marks registers as lost
// - Wake on next tick, halt four cycles
// - Count read copy refreshed each oscillator edge
// - Flag sync takes three cycles plus tick
// - Compare pins change on the timer tick; a select of 0 drives low at once while control A bit 7 is clear
// - Async select clocks timer from oscillator input
module tmr_pwm_timer #(
    parameter AW = 8                     // APB address width
) (
    input  wire          MCLK,
    input  wire          RSTN,
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [AW-1:0] PADDR,
    input  wire [31:0]   PWDATA,
    output reg  [31:0]   PRDATA,
    output reg           PREADY,
    output reg           PSLVERR,
    input  wire          ASYNC_OSC_INPUT,
    input  wire          SLEEP_SAVE,
    input  wire          PDOWN_WAKE,
    output reg           COMPARE_OUTPUT_PIN_A,
    output reg           COMPARE_OUTPUT_PIN_B,
    output reg           WAKE_REQ,
    output reg           CPU_HALT
);

// ----------------------------------------
// Functions
// ----------------------------------------
// Next compare pin level for one channel
function pin_nxt;
    input       cur;     // Present level
    input [1:0] com;     // Output select
    input       tgl_ok;  // Toggle allowed (channel A, wgm2 set)
    input       mup;     // Match counting up
    input       mdn;     // Match counting down
    input       top_ev;  // Reversal at top
    input       bot_ev;  // Reversal at bottom
    input       full;    // Compare at or above top
    input       empty;   // Compare at bottom
    reg         set_lvl;
    begin
        set_lvl = ~com[0];
        if (com[1]) begin
            if (top_ev)
                pin_nxt = full ? set_lvl : ~set_lvl;
            else if (bot_ev)
                pin_nxt = empty ? ~set_lvl : set_lvl;
            else if (mup)
                pin_nxt = ~set_lvl;
            else if (mdn)
                pin_nxt = set_lvl;
            else
                pin_nxt = cur;
        end else if (com[0] && tgl_ok && (mup || mdn)) begin
            pin_nxt = ~cur;
        end else if (com == 2'h0) begin
            pin_nxt = 1'b0;
        end else begin
            pin_nxt = cur;
        end
    end
endfunction

// Prescaler mask per clock select
function [9:0] psc_mask;
    input [2:0] cs;
    begin
        case (cs)
            3'h2:    psc_mask = 10'h007;
            3'h3:    psc_mask = 10'h01F;
            3'h4:    psc_mask = 10'h03F;
            3'h5:    psc_mask = 10'h07F;
            3'h6:    psc_mask = 10'h0FF;
            3'h7:    psc_mask = 10'h3FF;
            default: psc_mask = 10'h000;
        endcase
    end
endfunction

// ----------------------------------------
// State
// ----------------------------------------
reg  [7:0]  ctla_ff;          // Output selects, wgm low bits
reg  [7:0]  ctlb_ff;          // wgm2, clock select
reg  [7:0]  cnt_ff;           // Counter
reg  [7:0]  cmpa_ff;          // Compare A as written
reg  [7:0]  cmpb_ff;          // Compare B as written
reg  [7:0]  cmpa_act_ff;      // Compare A in use
reg  [7:0]  cmpb_act_ff;      // Compare B in use
reg  [7:0]  tmp_ff [0:4];     // Per-register temporaries
reg  [4:0]  busy_ff;          // Update busy flags
reg  [9:0]  edg_ff;           // Two-bit edge count per temporary
reg         as_ff;            // Async clock select
reg         lost_ff;          // Contents lost after power-down
reg         dir_ff;           // 1 while counting down
reg  [9:0]  psc_ff;           // Prescaler
reg  [2:0]  flags_ff;         // Overflow and compare flags
reg  [2:0]  ien_ff;           // Interrupt enables
reg  [2:0]  evp_ff [0:2];     // Flag sync pipeline
reg  [7:0]  cnt_rd_ff;        // Count copy for reads
reg         osc_s1_ff;        // Synchroniser stage one
reg         osc_s2_ff;        // Synchroniser stage two
reg         osc_s3_ff;        // Edge detect history
reg         arm_ff;           // Wake logic armed
reg         pend_ff;          // Wake pending for next tick
reg         slp_d_ff;         // Last sleep level
reg  [2:0]  halt_ff;          // Halt countdown
integer     i;

// ----------------------------------------
// Decode
// ----------------------------------------
wire [2:0]  wgm    = {ctlb_ff[`TMR_WGM2_BIT], ctla_ff[1:0]};
wire        dual   = (wgm == `TMR_WGM_PC_FF) || (wgm == `TMR_WGM_PC_A);
wire [7:0]  top    = (wgm == `TMR_WGM_PC_A) ? cmpa_act_ff : `TMR_MAX;
wire        osc_rise = osc_s2_ff & ~osc_s3_ff;
wire        src_en = as_ff ? osc_rise : 1'b1;
wire [9:0]  mask   = psc_mask(ctlb_ff[`TMR_CS_HI:0]);
wire        run    = ctlb_ff[`TMR_CS_HI:0] != 3'h0;
wire        tick   = src_en & run & ((psc_ff & mask) == mask);
wire        acc    = PSEL & PENABLE & PREADY;
wire        wr     = acc & PWRITE;
wire        at_top = dual & ~dir_ff & (cnt_ff >= top);
wire        top_ev = tick & at_top;
wire        bot_ev = tick & dual & dir_ff & (cnt_ff == 8'h00);
wire        blk_a  = busy_ff[`TMR_UB_COUNT] | busy_ff[`TMR_UB_CMPA];
wire        blk_b  = busy_ff[`TMR_UB_COUNT] | busy_ff[`TMR_UB_CMPB];
wire        m_a    = tick & ~blk_a & (cnt_ff == cmpa_act_ff);
wire        m_b    = tick & ~blk_b & (cnt_ff == cmpb_act_ff);
wire        ovf_ev = tick & (dual ? (dir_ff & cnt_ff == 8'h01)
                                  : (cnt_ff == `TMR_MAX));
wire [2:0]  ev_now = {m_b, m_a, ovf_ev};
wire [2:0]  ev_in  = as_ff ? evp_ff[`TMR_FLAG_SYNC-1] : ev_now;

// Register write target, one-hot by busy index
reg  [4:0]  wsel;
always @* begin
    wsel = 5'h00;
    if (wr) begin
        case (PADDR)
            `TMR_OFF_CTLA:  wsel[`TMR_UB_CTLA]  = 1'b1;
            `TMR_OFF_CTLB:  wsel[`TMR_UB_CTLB]  = 1'b1;
            `TMR_OFF_COUNT: wsel[`TMR_UB_COUNT] = 1'b1;
            `TMR_OFF_CMPA:  wsel[`TMR_UB_CMPA]  = 1'b1;
            `TMR_OFF_CMPB:  wsel[`TMR_UB_CMPB]  = 1'b1;
            default:        wsel = 5'h00;
        endcase
    end
end

// Commit strobe: second oscillator edge since the write
wire [4:0]  commit;
genvar g;
generate
    for (g = 0; g < 5; g = g + 1) begin : g_commit
        assign commit[g] = busy_ff[g] & osc_rise & ~wsel[g]
                         & (edg_ff[2*g+1:2*g] == `TMR_XFER_EDGES - 2'h1);
    end
endgenerate

// ----------------------------------------
// Oscillator sampling
// ----------------------------------------
// Second stage alone feeds the edge detector
always @(posedge MCLK) begin
    if (!RSTN) begin
        osc_s1_ff <= 1'b0;
        osc_s2_ff <= 1'b0;
        osc_s3_ff <= 1'b0;
    end else begin
        osc_s1_ff <= ASYNC_OSC_INPUT;
        osc_s2_ff <= osc_s1_ff;
        osc_s3_ff <= osc_s2_ff;
    end
end

// ----------------------------------------
// Register file and temporaries
// ----------------------------------------
// Sync mode writes land at once; async mode parks them
always @(posedge MCLK) begin
    if (!RSTN) begin
        ctla_ff <= `TMR_RST_BYTE;
        ctlb_ff <= `TMR_RST_BYTE;
        cmpa_ff <= `TMR_RST_BYTE;
        cmpb_ff <= `TMR_RST_BYTE;
        busy_ff <= 5'h00;
        edg_ff  <= 10'h000;
        as_ff   <= 1'b0;
        ien_ff  <= 3'h0;
        for (i = 0; i < 5; i = i + 1)
            tmp_ff[i] <= `TMR_RST_BYTE;
    end else begin
        for (i = 0; i < 5; i = i + 1) begin
            if (wsel[i] && as_ff) begin
                tmp_ff[i]          <= PWDATA[7:0];
                busy_ff[i]         <= 1'b1;
                edg_ff[2*i +: 2]   <= 2'h0;
            end else if (commit[i]) begin
                busy_ff[i]         <= 1'b0;
            end else if (busy_ff[i] && osc_rise) begin
                edg_ff[2*i +: 2]   <= edg_ff[2*i +: 2] + 2'h1;
            end
        end
        // Destinations, direct or from temporaries
        if (wsel[`TMR_UB_CTLA] && !as_ff)
            ctla_ff <= PWDATA[7:0];
        else if (commit[`TMR_UB_CTLA])
            ctla_ff <= tmp_ff[`TMR_UB_CTLA];
        if (wsel[`TMR_UB_CTLB] && !as_ff)
            ctlb_ff <= PWDATA[7:0];
        else if (commit[`TMR_UB_CTLB])
            ctlb_ff <= tmp_ff[`TMR_UB_CTLB];
        if (wsel[`TMR_UB_CMPA] && !as_ff)
            cmpa_ff <= PWDATA[7:0];
        else if (commit[`TMR_UB_CMPA])
            cmpa_ff <= tmp_ff[`TMR_UB_CMPA];
        if (wsel[`TMR_UB_CMPB] && !as_ff)
            cmpb_ff <= PWDATA[7:0];
        else if (commit[`TMR_UB_CMPB])
            cmpb_ff <= tmp_ff[`TMR_UB_CMPB];
        // Source switch is guarded by software
        if (wr && PADDR == `TMR_OFF_STAT)
            as_ff <= PWDATA[`TMR_AS_BIT];
        if (wr && PADDR == `TMR_OFF_IEN)
            ien_ff <= PWDATA[2:0];
    end
end

// ----------------------------------------
// Prescaler
// ----------------------------------------
// Free count of source edges; mask picks the ratio
always @(posedge MCLK) begin
    if (!RSTN)
        psc_ff <= 10'h000;
    else if (src_en)
        psc_ff <= psc_ff + 10'h001;
end

// ----------------------------------------
// Counter core
// ----------------------------------------
// Dual slope: 0 up to top, hold top one tick, down to 0
always @(posedge MCLK) begin
    if (!RSTN) begin
        cnt_ff      <= `TMR_RST_BYTE;
        dir_ff      <= 1'b0;
        cmpa_act_ff <= `TMR_RST_BYTE;
        cmpb_act_ff <= `TMR_RST_BYTE;
    end else if (wsel[`TMR_UB_COUNT] && !as_ff) begin
        cnt_ff <= PWDATA[7:0];
    end else if (commit[`TMR_UB_COUNT]) begin
        cnt_ff <= tmp_ff[`TMR_UB_COUNT];
    end else if (tick) begin
        if (dual) begin
            if (!dir_ff) begin
                if (at_top) begin
                    // Top was held for this tick; now turn
                    cnt_ff      <= (top == 8'h00) ? 8'h00 : cnt_ff - 8'h01;
                    dir_ff      <= 1'b1;
                    cmpa_act_ff <= cmpa_ff;
                    cmpb_act_ff <= cmpb_ff;
                end else begin
                    cnt_ff <= cnt_ff + 8'h01;
                end
            end else if (cnt_ff == 8'h00) begin
                // 510 ticks per period when top is 0xFF
                cnt_ff <= (top == 8'h00) ? 8'h00 : 8'h01;
                dir_ff <= 1'b0;
            end else begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end else begin
            // Other modes: plain up count, buffers follow at once
            cnt_ff      <= cnt_ff + 8'h01;
            dir_ff      <= 1'b0;
            cmpa_act_ff <= cmpa_ff;
            cmpb_act_ff <= cmpb_ff;
        end
    end
end

// ----------------------------------------
// Compare pins
// ----------------------------------------
// Updated on the tick itself, or every cycle while control A bit 7 is clear
always @(posedge MCLK) begin
    if (!RSTN) begin
        COMPARE_OUTPUT_PIN_A <= 1'b0;
        COMPARE_OUTPUT_PIN_B <= 1'b0;
    end else if (tick || !ctla_ff[`TMR_COMA_HI]) begin
        COMPARE_OUTPUT_PIN_A <= pin_nxt(COMPARE_OUTPUT_PIN_A,
            ctla_ff[`TMR_COMA_HI:`TMR_COMA_LO], ctlb_ff[`TMR_WGM2_BIT],
            m_a & ~dir_ff, m_a & dir_ff, top_ev, bot_ev,
            cmpa_act_ff >= top, cmpa_act_ff == 8'h00);
        COMPARE_OUTPUT_PIN_B <= pin_nxt(COMPARE_OUTPUT_PIN_B,
            ctla_ff[`TMR_COMB_HI:`TMR_COMB_LO], 1'b0,
            m_b & ~dir_ff, m_b & dir_ff, top_ev, bot_ev,
            cmpb_act_ff >= top, cmpb_act_ff == 8'h00);
    end
end

// ----------------------------------------
// Flags and their synchronisation
// ----------------------------------------
// Set wins over a write-one clear in the same cycle
always @(posedge MCLK) begin
    if (!RSTN) begin
        flags_ff <= 3'h0;
        for (i = 0; i < `TMR_FLAG_SYNC; i = i + 1)
            evp_ff[i] <= 3'h0;
    end else begin
        evp_ff[0] <= ev_now;
        for (i = 1; i < `TMR_FLAG_SYNC; i = i + 1)
            evp_ff[i] <= evp_ff[i-1];
        if (wr && PADDR == `TMR_OFF_FLAGS)
            flags_ff <= (flags_ff & ~PWDATA[2:0]) | ev_in;
        else
            flags_ff <= flags_ff | ev_in;
    end
end

// ----------------------------------------
// Read copy of the counter
// ----------------------------------------
// Async: refreshed only on oscillator edges, so a stale
// pre-sleep value reads back until the next edge
always @(posedge MCLK) begin
    if (!RSTN)
        cnt_rd_ff <= `TMR_RST_BYTE;
    else if (!as_ff || osc_rise)
        cnt_rd_ff <= cnt_ff;
end

// ----------------------------------------
// Wake and halt sequencing
// ----------------------------------------
always @(posedge MCLK) begin
    if (!RSTN) begin
        arm_ff   <= 1'b1;
        pend_ff  <= 1'b0;
        WAKE_REQ <= 1'b0;
        slp_d_ff <= 1'b0;
        halt_ff  <= 3'h0;
        CPU_HALT <= 1'b0;
        lost_ff  <= 1'b0;
    end else begin
        slp_d_ff <= SLEEP_SAVE;
        // Rearm needs one oscillator cycle after a wake
        if (WAKE_REQ)
            arm_ff <= 1'b0;
        else if (osc_rise)
            arm_ff <= 1'b1;
        if (!SLEEP_SAVE)
            pend_ff <= 1'b0;
        else if (arm_ff && |(ev_now & ien_ff))
            pend_ff <= 1'b1;
        // Wake starts on the tick after the condition
        if (!SLEEP_SAVE)
            WAKE_REQ <= 1'b0;
        else if (pend_ff && tick)
            WAKE_REQ <= 1'b1;
        // Core held four cycles once it comes back up
        if (slp_d_ff && !SLEEP_SAVE)
            halt_ff <= `TMR_HALT_CYC;
        else if (halt_ff != 3'h0)
            halt_ff <= halt_ff - 3'h1;
        CPU_HALT <= (slp_d_ff && !SLEEP_SAVE) || (halt_ff > 3'h1);
        // Registers are not trusted after a power-down wake
        if (PDOWN_WAKE)
            lost_ff <= 1'b1;
        else if (wr && PADDR == `TMR_OFF_STAT && PWDATA[`TMR_LOST_BIT])
            lost_ff <= 1'b0;
    end
end

// ----------------------------------------
// APB slave
// ----------------------------------------
// One wait state: ready rises the cycle after access starts
reg  [31:0] rd_mux;
reg         rd_err;
always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (PADDR)
        `TMR_OFF_CTLA:  rd_mux[7:0] = ctla_ff;
        `TMR_OFF_CTLB:  rd_mux[7:0] = ctlb_ff;
        `TMR_OFF_COUNT: rd_mux[7:0] = cnt_rd_ff;
        `TMR_OFF_CMPA:  rd_mux[7:0] = cmpa_ff;
        `TMR_OFF_CMPB:  rd_mux[7:0] = cmpb_ff;
        `TMR_OFF_STAT:  rd_mux[7:0] = {1'b0, lost_ff, as_ff, busy_ff};
        `TMR_OFF_FLAGS: rd_mux[2:0] = flags_ff;
        `TMR_OFF_IEN:   rd_mux[2:0] = ien_ff;
        default:        rd_err      = 1'b1;
    endcase
end

always @(posedge MCLK) begin
    if (!RSTN) begin
        PREADY  <= 1'b0;
        PRDATA  <= 32'h0000_0000;
        PSLVERR <= 1'b0;
    end else begin
        PREADY <= PSEL & PENABLE & ~PREADY;
        if (PSEL && PENABLE && !PREADY) begin
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
            PSLVERR <= rd_err;
        end else begin
            PSLVERR <= 1'b0;
        end
    end
end

endmodule // tmr_pwm_timer
`default_nettype wire

// ==== verification/tmr_pwm_monitor.sv ====
// Checker for the dual-slope timer: bus answer, wake and halt relations.
// Assumes it is bound to tmr_pwm_timer and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module tmr_pwm_monitor (
    input wire logic        MCLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SLEEP_SAVE,
    input wire logic        COMPARE_OUTPUT_PIN_A,
    input wire logic        COMPARE_OUTPUT_PIN_B,
    input wire logic        WAKE_REQ,
    input wire logic        CPU_HALT
);
    // ----------------------------------------
    // Clock and reset
    // ----------------------------------------
    default clocking mon_cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    // One wait state
    ready_wait_a: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
        else $error("bus answer late");
    // Answer inside access, one cycle
    ready_single_a: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
        else $error("stray bus answer");
    // Refused read gives zero data
    err_read_a: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0))
        else $error("bad error answer");
    // Upper lanes read zero
    upper_zero_a: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    // ----------------------------------------
    // Reset, wake and halt
    // ----------------------------------------
    // Outputs leave reset idle
    reset_out_a: assert property ($rose(RSTN) |-> !PREADY && !WAKE_REQ && !CPU_HALT
        && !COMPARE_OUTPUT_PIN_A && !COMPARE_OUTPUT_PIN_B)
        else $error("reset not idle");
    // Halt lasts four cycles
    halt_len_a: assert property ($rose(CPU_HALT) |-> CPU_HALT[*4] ##1 !CPU_HALT)
        else $error("halt length");
    // Wake holds while asleep
    wake_hold_a: assert property (WAKE_REQ && SLEEP_SAVE |=> WAKE_REQ)
        else $error("wake dropped");
    // Wake rises only in sleep
    wake_src_a: assert property ($rose(WAKE_REQ) |-> SLEEP_SAVE)
        else $error("stray wake");
    // Scenarios reached
    cover property (PSLVERR);
    cover property ($rose(CPU_HALT));
    cover property ($rose(COMPARE_OUTPUT_PIN_B));
endmodule // tmr_pwm_monitor
bind tmr_pwm_timer tmr_pwm_monitor u_mon (.MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SLEEP_SAVE(SLEEP_SAVE), .COMPARE_OUTPUT_PIN_A(COMPARE_OUTPUT_PIN_A),
    .COMPARE_OUTPUT_PIN_B(COMPARE_OUTPUT_PIN_B), .WAKE_REQ(WAKE_REQ), .CPU_HALT(CPU_HALT));
`default_nettype wire

// ==== verification/tmr_osc_model.sv ====
// Low-rate oscillator that feeds the timer's asynchronous clock input.
// Assumes a 1 ns time unit; phase is unrelated to the processor clock.
`timescale 1ns/1ps
`default_nettype none
module tmr_osc_model #(
    parameter int HALF_NS = 103          // Half period, far above four MCLK
) (
    input  wire logic en,                // Oscillator running
    output var  logic osc                // Oscillator level
);
    // ----------------------------------------
    // Free-running crystal, stopped only when disabled
    // ----------------------------------------
    initial begin
        osc = 1'b0;
        #7.5;
        forever begin
            #(HALF_NS);
            osc = en ? ~osc : 1'b0;      // Odd start offset avoids edge alignment
        end
    end
endmodule // tmr_osc_model
`default_nettype wire

// ==== verification/async_timer_phase_correct_pwm_tb_top.sv ====
// Self-checking bench: registers, PWM periods, async transfers, sleep.
// Assumes tmr_pwm_timer, tmr_osc_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module async_timer_phase_correct_pwm_tb_top;
    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    typedef struct {bit w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} tmr_reg_t;
    typedef struct {logic [7:0] ca; logic [7:0] cb; logic [7:0] ma; logic [7:0] mb;
                    bit s; int per; int hi;} tmr_pwm_t;
    logic        mclk, rst_n, psel, penable, pwrite, sleep, pdwn, osc_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rdat;
    logic        rerr;
    wire  logic [31:0] prdata;
    wire  logic  pready, pslverr, osc, pin_a, pin_b, wake, halt;
    int          n_fail, num_checks, per, hi, k;
    time         t0;
    // Reads give reset or written-back values; unmapped place is refused
    tmr_reg_t regs [11] = '{'{0, `TMR_OFF_CTLA, 0, 0, 0}, '{0, `TMR_OFF_STAT, 0, 0, 0},
        '{0, `TMR_OFF_FLAGS, 0, 0, 0}, '{0, `TMR_OFF_COUNT, 0, 0, 0},
        '{1, `TMR_OFF_CMPA, 32'h3C, 0, 0}, '{0, `TMR_OFF_CMPA, 0, 32'h3C, 0},
        '{1, `TMR_OFF_IEN, 32'h107, 0, 0}, '{0, `TMR_OFF_IEN, 0, 32'h7, 0},
        '{1, `TMR_OFF_IEN, 0, 0, 0}, '{1, 8'h20, 32'h5A, 0, 1}, '{0, 8'h20, 0, 0, 1}};
    // Period and high counts in MCLK cycles per setting
    tmr_pwm_t pwms [4] = '{'{8'hB1, 8'h01, 8'h40, 8'h40, 0, 510, 128},
        '{8'hB1, 8'h01, 8'h40, 8'h40, 1, 510, 382}, '{8'hB1, 8'h02, 8'h40, 8'h40, 0, 4080, 1024},
        '{8'h21, 8'h09, 8'h20, 8'h10, 1, 64, 32}};
    logic [7:0] aoff [5] = '{`TMR_OFF_CTLB, `TMR_OFF_CTLA, `TMR_OFF_CMPB, `TMR_OFF_CMPA,
                             `TMR_OFF_COUNT};
    logic [7:0] aval [5] = '{8'h01, 8'hA1, 8'h10, 8'h80, 8'h00};
    tmr_pwm_timer u_dut (.MCLK(mclk), .RSTN(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ASYNC_OSC_INPUT(osc), .SLEEP_SAVE(sleep), .PDOWN_WAKE(pdwn),
        .COMPARE_OUTPUT_PIN_A(pin_a), .COMPARE_OUTPUT_PIN_B(pin_b), .WAKE_REQ(wake),
        .CPU_HALT(halt));
    tmr_osc_model u_osc (.en(osc_en), .osc(osc));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Verdict; every expired wait except the busy poll ends here
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tmo();
        `CHK(1'b0, 1'b1)
        end_of_test();
    endtask
    // One transfer, held until ready is sampled
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) tmo();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Skip two rises, then time one period
    task automatic meas(input bit s, input int lim);
        logic q, p, rise;
        q = 1'b1;
        per = 0;
        hi = 0;
        for (int r = 0; r < 3; r++) begin
            for (k = 0; k < lim; k++) begin
                @(posedge mclk);
                p = s ? pin_b : pin_a;
                if (r == 2) per++;
                if (r == 2 && p === 1'b1) hi++;
                rise = (q === 1'b0 && p === 1'b1);
                q = p;
                if (rise) break;
            end
            if (k == lim) tmo();
        end
    endtask
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {rst_n, psel, penable, pwrite, sleep, pdwn} = 6'h00;
        {paddr, pwdata, n_fail, num_checks} = '0;
        osc_en = 1'b1;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (regs[i]) begin
            apb(regs[i].w, regs[i].a, regs[i].d);
            `CHK(rerr, regs[i].e)
            if (!regs[i].w) `CHK(rdat, regs[i].x)
        end
        $display("test registers done");
        foreach (pwms[i]) begin
            apb(1'b1, `TMR_OFF_CMPA, pwms[i].ma);
            apb(1'b1, `TMR_OFF_CMPB, pwms[i].mb);
            apb(1'b1, `TMR_OFF_CTLA, pwms[i].ca);
            apb(1'b1, `TMR_OFF_CTLB, pwms[i].cb);
            meas(pwms[i].s, 2 * pwms[i].per + 100);
            `CHK(per, pwms[i].per)
            `CHK(hi, pwms[i].hi)
        end
        $display("test pwm periods done");
        // Compare 0 on A, max on B: flat levels
        apb(1'b1, `TMR_OFF_CMPA, 32'h00);
        apb(1'b1, `TMR_OFF_CMPB, 32'hFF);
        apb(1'b1, `TMR_OFF_CTLA, 32'hA1);
        apb(1'b1, `TMR_OFF_CTLB, 32'h01);
        repeat (1100) @(posedge mclk);
        {hi, per} = '0;
        repeat (520) begin
            @(posedge mclk);
            if (pin_a === 1'b1) hi++;
            if (pin_b === 1'b1) per++;
        end
        `CHK(hi, 0)
        `CHK(per, 520)
        apb(1'b1, `TMR_OFF_FLAGS, 32'h07);
        repeat (520) @(posedge mclk);
        apb(1'b0, `TMR_OFF_FLAGS, 32'h0);
        `CHK(rdat[`TMR_FL_OVF], 1'b1)
        apb(1'b1, `TMR_OFF_CTLB, 32'h00);
        apb(1'b1, `TMR_OFF_FLAGS, 32'h07);
        apb(1'b0, `TMR_OFF_FLAGS, 32'h0);
        `CHK(rdat, 32'h0)
        $display("test levels and overflow done");
        // Safe source switch, rewrite, wait busy
        apb(1'b1, `TMR_OFF_STAT, 32'h20);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, aoff[i], aval[i]);
            t0 = $time;
            apb(1'b0, `TMR_OFF_STAT, 32'h0);
            `CHK(rdat, 32'h20 | (32'h1 << i))
            k = 0;
            do begin
                apb(1'b0, `TMR_OFF_STAT, 32'h0);
                k++;
            end while (rdat !== 32'h20 && k < 40);
            `CHK(rdat, 32'h20)
            `CHK(($time - t0) >= 200, 1'b1)
        end
        apb(1'b1, `TMR_OFF_FLAGS, 32'h07);
        apb(1'b1, `TMR_OFF_IEN, 32'h01);
        sleep <= 1'b1;
        for (k = 0; k < 13000 && wake !== 1'b1; k++) @(posedge mclk);
        if (k == 13000) tmo();
        sleep <= 1'b0;
        hi = 0;
        repeat (22) begin
            @(posedge mclk);
            if (halt === 1'b1) hi++;
        end
        `CHK(hi, 4)
        apb(1'b0, `TMR_OFF_COUNT, 32'h0);
        `CHK(rdat > 0 && rdat < 3, 1'b1)
        apb(1'b0, `TMR_OFF_FLAGS, 32'h0);
        `CHK(rdat[`TMR_FL_OVF], 1'b1)
        $display("test async and wake done");
        pdwn <= 1'b1;
        @(posedge mclk);
        pdwn <= 1'b0;
        apb(1'b0, `TMR_OFF_STAT, 32'h0);
        `CHK(rdat[`TMR_LOST_BIT], 1'b1)
        apb(1'b1, `TMR_OFF_STAT, 32'h60);
        apb(1'b0, `TMR_OFF_STAT, 32'h0);
        `CHK(rdat, 32'h20)
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, `TMR_OFF_STAT, 32'h0);
        `CHK(rdat, 32'h0)
        `CHK({pin_a, pin_b, wake, halt}, 4'h0)
        $display("test lost flag and reset done");
        end_of_test();
    end
endmodule // async_timer_phase_correct_pwm_tb_top
`default_nettype wire
